//--- awd_window_detector.sv
// adc window detector: limit registers, result capture, sticky window flag, interrupt
// assumes the converter pulses conv_done for one cycle with conv_result valid
//
// Design decision made here: the plain strobed port.
`timescale 1ns/100ps

// Operation
// R1 - Every conversion result is compared against both limit words and a hit is signalled.
// R2 - The window compare flag is readable in the converter control register for polling.
// R3 - Each limit is loaded as separate high and low bytes, held as comparison references.
// R4 - The limit ordering selects whether the flag marks results inside or outside the window.
// R5 - The less-than high byte is a read/write register at address 0xC7 holding bits 15 to 8.
// R6 - With less-than above greater-than both tests must hold, otherwise either test suffices.
// R7 - In differential configuration result and limits compare as two's complement values.
// R8 - The flag stays set until software clears it; a failed compare leaves it unchanged.
module awd_window_detector
(
   input  wire logic        ref_clk,
   input  wire logic        reset_n,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_write,
   input  wire logic        reg_read,
   output logic      [7:0]  reg_rdata,
   input  wire logic        conv_done,
   input  wire logic [15:0] conv_result,
   output logic             window_irq,
   output logic             window_compare_flag,
   output logic             input_pair_config,
   output logic             result_left_justify_select
);
   // ***************************************************
   // register state
   // ***************************************************
   logic [7:0]  gt_high_q, gt_low_q, lt_high_q, lt_low_q;
   logic [7:0]  ctrl_q;
   logic [7:0]  mask_q;
   logic [15:0] result_q;
   logic        flag_q;
   logic        flag_d;
   logic [7:0]  rdata_q;
   logic [7:0]  rdata_d;

   // ***************************************************
   // decode
   // ***************************************************
   wire wr_gt_high = reg_write & (reg_addr == awd_pkg::ADDR_GT_HIGH);
   wire wr_gt_low  = reg_write & (reg_addr == awd_pkg::ADDR_GT_LOW);
   wire wr_lt_high = reg_write & (reg_addr == awd_pkg::ADDR_LT_HIGH);
   wire wr_lt_low  = reg_write & (reg_addr == awd_pkg::ADDR_LT_LOW);
   wire wr_ctrl    = reg_write & (reg_addr == awd_pkg::ADDR_CTRL);
   wire wr_mask    = reg_write & (reg_addr == awd_pkg::ADDR_IRQ_MASK);
   wire flag_clear = wr_ctrl & reg_wdata[awd_pkg::CTRL_FLAG_BIT];

   // ***************************************************
   // comparator
   // ***************************************************
   awd_cmp_if cmp_bus ();
   assign cmp_bus.result       = conv_result;
   assign cmp_bus.less_than    = {lt_high_q, lt_low_q}; // R3
   assign cmp_bus.greater_than = {gt_high_q, gt_low_q}; // R3
   assign cmp_bus.signed_mode  = ctrl_q[awd_pkg::CTRL_DIFF_BIT]; // R7

   awd_compare u_compare
   (
      .c (cmp_bus.cmp)
   );

   wire hit_event = conv_done & cmp_bus.hit; // R1

   // a hit in the clearing cycle wins so no event is lost
   always_comb
   begin
      flag_d = flag_q;
      if (flag_clear)
      begin
         flag_d = 1'b0;
      end
      if (hit_event)
      begin
         flag_d = 1'b1; // R8
      end
   end

   // ***************************************************
   // registers
   // ***************************************************
   // limit bytes load one at a time, so a half-written limit is compared until both land
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         gt_high_q <= awd_pkg::LIMIT_RESET;
      end
      else if (wr_gt_high)
      begin
         gt_high_q <= reg_wdata; // R3
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         gt_low_q <= awd_pkg::LIMIT_RESET;
      end
      else if (wr_gt_low)
      begin
         gt_low_q <= reg_wdata; // R3
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         lt_high_q <= awd_pkg::LIMIT_RESET;
      end
      else if (wr_lt_high)
      begin
         lt_high_q <= reg_wdata; // R5
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         lt_low_q <= awd_pkg::LIMIT_RESET;
      end
      else if (wr_lt_low)
      begin
         lt_low_q <= reg_wdata; // R3
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ctrl_q <= awd_pkg::CTRL_RESET;
      end
      else if (wr_ctrl)
      begin
         ctrl_q <= reg_wdata;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         mask_q <= awd_pkg::MASK_RESET;
      end
      else if (wr_mask)
      begin
         mask_q <= reg_wdata;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         result_q <= awd_pkg::WORD_RESET;
      end
      else if (conv_done)
      begin
         result_q <= conv_result;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         flag_q <= 1'b0;
      end
      else
      begin
         flag_q <= flag_d; // R8
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rdata_q <= 8'h00;
      end
      else
      begin
         rdata_q <= rdata_d;
      end
   end

   // ***************************************************
   // read path
   // ***************************************************
   // flag bit of the control register reflects live flag, other bits as stored
   wire [7:0] ctrl_view = {ctrl_q[7:3], flag_q, ctrl_q[1:0]}; // R2

   always_comb
   begin
      rdata_d = 8'h00;
      if (reg_read)
      begin
         unique case (reg_addr)
            awd_pkg::ADDR_GT_HIGH:   rdata_d = gt_high_q;
            awd_pkg::ADDR_GT_LOW:    rdata_d = gt_low_q;
            awd_pkg::ADDR_LT_HIGH:   rdata_d = lt_high_q; // R5
            awd_pkg::ADDR_LT_LOW:    rdata_d = lt_low_q;
            awd_pkg::ADDR_CTRL:      rdata_d = ctrl_view; // R2
            awd_pkg::ADDR_IRQ_MASK:  rdata_d = mask_q;
            awd_pkg::ADDR_RESULT_LO: rdata_d = result_q[7:0];
            awd_pkg::ADDR_RESULT_HI: rdata_d = result_q[15:8];
            default:                 rdata_d = 8'h00;
         endcase
      end
   end

   assign reg_rdata                  = rdata_q;
   assign window_compare_flag        = flag_q; // R2
   assign window_irq                 = flag_q & mask_q[awd_pkg::MASK_FLAG_BIT]; // R1
   assign input_pair_config          = ctrl_q[awd_pkg::CTRL_DIFF_BIT];
   assign result_left_justify_select = ctrl_q[awd_pkg::CTRL_LJUST_BIT];
endmodule

//--- awd_pkg.sv
// package for the adc window detector: register map, field positions, reset values
// assumes an 8-bit special-function register port in front of the block
package awd_pkg;
   // ***************************************************
   // register offsets
   // ***************************************************
   localparam logic [7:0] ADDR_GT_HIGH   = 8'hC4;
   localparam logic [7:0] ADDR_GT_LOW    = 8'hC5;
   localparam logic [7:0] ADDR_LT_LOW    = 8'hC6;
   localparam logic [7:0] ADDR_LT_HIGH   = 8'hC7;
   localparam logic [7:0] ADDR_CTRL      = 8'hE8;
   localparam logic [7:0] ADDR_IRQ_MASK  = 8'hE9;
   localparam logic [7:0] ADDR_RESULT_LO = 8'hBE;
   localparam logic [7:0] ADDR_RESULT_HI = 8'hBF;
   // ***************************************************
   // field positions and reset values
   // ***************************************************
   localparam int unsigned CTRL_FLAG_BIT   = 2;
   localparam int unsigned CTRL_DIFF_BIT   = 0;
   localparam int unsigned CTRL_LJUST_BIT  = 1;
   localparam int unsigned MASK_FLAG_BIT   = 2;
   localparam logic [7:0]  LIMIT_RESET     = 8'h00;
   localparam logic [7:0]  CTRL_RESET      = 8'h00;
   localparam logic [7:0]  MASK_RESET      = 8'h00;
   localparam logic [15:0] WORD_RESET      = 16'h0000;
endpackage

//--- awd_cmp_if.sv
// interface carrying one conversion result and the limits into the comparator
// assumes a single clock domain; the comparator is purely combinational
`timescale 1ns/100ps
interface awd_cmp_if;
   logic [15:0] result;
   logic [15:0] less_than;
   logic [15:0] greater_than;
   logic        signed_mode;
   logic        hit;
   modport ctrl (output result, output less_than, output greater_than,
                 output signed_mode, input hit);
   modport cmp  (input result, input less_than, input greater_than,
                 input signed_mode, output hit);
endinterface

//--- awd_compare.sv
// window comparison of one result word against the two limits
// assumes all inputs stable in the cycle the end-of-conversion strobe is seen
`timescale 1ns/100ps
module awd_compare
(
   awd_cmp_if.cmp c
);
   wire below_lt;
   wire above_gt;
   wire inside_mode;

   // differential results are two's complement, so 0xFFFF is minus one
   assign below_lt = c.signed_mode ? ($signed(c.result) < $signed(c.less_than))
                                   : (c.result < c.less_than); // R7
   assign above_gt = c.signed_mode ? ($signed(c.result) > $signed(c.greater_than))
                                   : (c.result > c.greater_than); // R7
   assign inside_mode = c.signed_mode ? ($signed(c.less_than) > $signed(c.greater_than))
                                      : (c.less_than > c.greater_than);
   // ordered limits give an inside window, reversed limits an outside one
   assign c.hit = inside_mode ? (below_lt & above_gt) : (below_lt | above_gt); // R4 R6
endmodule

//--- awd_sva.sv
// port-level assertions for the adc window detector
// assumes one clock domain and the register map of awd_pkg
`timescale 1ns/100ps
module awd_sva
(
   input wire logic        ref_clk,
   input wire logic        reset_n,
   input wire logic [7:0]  reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_write,
   input wire logic        reg_read,
   input wire logic [7:0]  reg_rdata,
   input wire logic        conv_done,
   input wire logic [15:0] conv_result,
   input wire logic        window_irq,
   input wire logic        window_compare_flag,
   input wire logic        input_pair_config,
   input wire logic        result_left_justify_select
);
   // ******
   // checks
   // ******
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);
   wire ctl_wr = reg_write && reg_addr == awd_pkg::ADDR_CTRL;
   wire lt_wr  = reg_write && reg_addr == awd_pkg::ADDR_LT_HIGH;
   wire lt_rd  = reg_read && reg_addr == awd_pkg::ADDR_LT_HIGH;
   wire clr_wr = ctl_wr && reg_wdata[awd_pkg::CTRL_FLAG_BIT];
   a_irq_needs_flag: assert property (window_irq |-> window_compare_flag)
      else $error("irq high without flag");
   a_flag_rise_cause: assert property ($rose(window_compare_flag) |-> $past(conv_done))
      else $error("flag rose without conversion");
   a_flag_holds: assert property (window_compare_flag && !clr_wr |=> window_compare_flag)
      else $error("flag dropped without clear");
   a_flag_clears: assert property (clr_wr && !conv_done |=> !window_compare_flag)
      else $error("flag not cleared");
   a_read_idle: assert property (!reg_read |=> reg_rdata == 8'h00)
      else $error("read data outside read slot");
   a_lt_readback: assert property (lt_wr ##1 lt_rd |=> reg_rdata == $past(reg_wdata, 2))
      else $error("less-than high byte readback wrong");
   a_diff_mode: assert property (ctl_wr |=> input_pair_config == $past(reg_wdata[0]))
      else $error("differential bit not stored");
   a_ljust_mode: assert property (ctl_wr |=> result_left_justify_select == $past(reg_wdata[1]))
      else $error("justify bit not stored");
   c_flag_set: cover property ($rose(window_compare_flag));
   c_irq: cover property (window_irq);
   c_clear: cover property (ctl_wr && reg_wdata[2] && window_compare_flag);
endmodule
bind awd_window_detector awd_sva awd_sva_i (.ref_clk(ref_clk), .reset_n(reset_n),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
   .reg_rdata(reg_rdata), .conv_done(conv_done), .conv_result(conv_result),
   .window_irq(window_irq), .window_compare_flag(window_compare_flag),
   .input_pair_config(input_pair_config),
   .result_left_justify_select(result_left_justify_select));

//--- awd_adc_model.sv
// converter model: a start request returns one result LAT+1 cycles later
// assumes the bench requests one conversion at a time
`timescale 1ns/100ps
module awd_adc_model
#(parameter int LAT = 2)
(
   input wire logic         ref_clk,
   input wire logic         reset_n,
   input wire logic         start,
   input wire logic [15:0]  value,
   output logic             conv_done,
   output logic [15:0]      conv_result
);
   int cnt_q;
   // result word toggles outside the done pulse so a sample one cycle late never matches
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cnt_q <= 0;
         conv_done <= 1'b0;
         conv_result <= 16'h0000;
      end
      else
      begin
         cnt_q <= start ? LAT : (cnt_q != 0 ? cnt_q - 1 : 0);
         conv_done <= cnt_q == 1;
         conv_result <= cnt_q == 1 ? value : ~conv_result;
      end
   end
endmodule

//--- test_adc_window_detector.sv
// self-checking bench for the adc window detector against an integer model
// assumes awd_pkg offsets and a two-cycle converter model
`timescale 1ns/100ps
module test_adc_window_detector;
   logic        ref_clk = 1'b0, reset_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0, start = 1'b0;
   logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rd_q;
   logic [15:0] value = 16'h0000, conv_result, lt, gt, r;
   logic        conv_done, flag, irq, diff, ljust, exp_flag, sm;
   logic [31:0] x = 32'h00015A43;
   logic [32:0] cfg [4] = '{{16'h0200, 16'h0100, 1'b0}, {16'h0100, 16'h0200, 1'b0},
                            {16'h0100, 16'hFFFF, 1'b1}, {16'hFFFF, 16'h0100, 1'b1}};
   int          errors = 0, n_checks = 0, cyc = 0;
   awd_adc_model #(.LAT(2)) awd_adc_model_i (.ref_clk(ref_clk), .reset_n(reset_n),
      .start(start), .value(value), .conv_done(conv_done), .conv_result(conv_result));
   awd_window_detector awd_window_detector_i (.ref_clk(ref_clk), .reset_n(reset_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .conv_done(conv_done), .conv_result(conv_result),
      .window_irq(irq), .window_compare_flag(flag), .input_pair_config(diff),
      .result_left_justify_select(ljust));
   initial
   begin
      forever #5 ref_clk = ~ref_clk;
   end
   // ******
   // tasks
   // ******
   function automatic logic [15:0] xs();
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x[15:0];
   endfunction
   function automatic logic hit(logic [15:0] rv, logic [15:0] l, logic [15:0] g, logic s);
      int ri, li, gi;
      ri = s ? int'($signed(rv)) : int'(rv);
      li = s ? int'($signed(l)) : int'(l);
      gi = s ? int'($signed(g)) : int'(g);
      return (li > gi) ? (ri < li && ri > gi) : (ri < li || ri > gi);
   endfunction
   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      n_checks++;
      if (g !== e)
      begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   // the write strobe stays up until the next task takes the bus, so back-to-back
   // writes never assign it twice in one time step
   task automatic wr(logic [7:0] a, logic [7:0] d);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
   endtask
   task automatic rd(logic [7:0] a, output logic [7:0] d);
      reg_write <= 1'b0;
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_read <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic conv(logic [15:0] rv);
      reg_write <= 1'b0;
      start <= 1'b1;
      value <= rv;
      @(posedge ref_clk);
      start <= 1'b0;
      repeat (4) @(posedge ref_clk);
      #1;
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         errors++;
         complete_run;
      end
   end
   initial
   begin
      repeat (20) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(posedge ref_clk);
      rd(awd_pkg::ADDR_LT_HIGH, rd_q);
      chk("lt_high reset", 16'h0000, rd_q);
      rd(8'h00, rd_q);
      chk("unmapped", 16'h0000, rd_q);
      $display("test reset done");
      for (int c = 0; c < 4; c++)
      begin
         {lt, gt, sm} = cfg[c];
         wr(awd_pkg::ADDR_LT_LOW, lt[7:0]);
         wr(awd_pkg::ADDR_GT_HIGH, gt[15:8]);
         wr(awd_pkg::ADDR_GT_LOW, gt[7:0]);
         wr(awd_pkg::ADDR_LT_HIGH, lt[15:8]);
         rd(awd_pkg::ADDR_LT_HIGH, rd_q);
         chk("lt_high", lt[15:8], rd_q);
         rd(awd_pkg::ADDR_GT_LOW, rd_q);
         chk("gt_low", gt[7:0], rd_q);
         wr(awd_pkg::ADDR_IRQ_MASK, {5'h00, c[0], 2'h0});
         wr(awd_pkg::ADDR_CTRL, {5'h00, 1'b1, c[1], cfg[c][0]});
         exp_flag = 1'b0;
         for (int k = 0; k < 12; k++)
         begin
            r = k == 0 ? lt : k == 1 ? lt - 1 : k == 2 ? gt : k == 3 ? gt + 1 : xs();
            conv(r);
            exp_flag |= hit(r, lt, gt, cfg[c][0]);
            chk("flag", exp_flag, flag);
            chk("irq", exp_flag & c[0], irq);
            rd(awd_pkg::ADDR_CTRL, rd_q);
            chk("ctrl flag", exp_flag, rd_q[2]);
            rd(awd_pkg::ADDR_RESULT_LO, rd_q);
            chk("result low", r[7:0], rd_q);
            rd(awd_pkg::ADDR_RESULT_HI, rd_q);
            chk("result high", r[15:8], rd_q);
            // clearing only every third result leaves misses landing on a set flag
            if (k % 3 == 2)
            begin
               wr(awd_pkg::ADDR_CTRL, {5'h00, 1'b1, c[1], cfg[c][0]});
               exp_flag = 1'b0;
            end
         end
         chk("diff", sm, diff);
         chk("ljust", c[1], ljust);
         $display("test limits %0d done", c);
      end
      complete_run;
   end
endmodule
